// File: dv/dot_clock_select_tb.sv
// Self-checking testbench for the dot-clock selection and synthesizer access block.
`default_nettype none

module dot_clock_select_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dot_clock_pkg::*;

	// A short settle time keeps the lock waits brief.
	localparam int LOCK_N = 4;

	// Bench-driven inputs, all given a value at time zero.
	logic       clk_sys   = 1'b0;
	logic       reset     = 1'b1;
	logic [7:0] reg_index = 8'h00;
	logic       reg_write = 1'b0;
	logic       reg_read  = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic       in_zero   = 1'b0;
	logic       in_one    = 1'b0;
	logic       in_two_p  = 1'b0;
	logic       in_two_n  = 1'b1;
	logic       in_pix    = 1'b0;
	logic [3:0] pat       = 4'h0;
	logic       run1      = 1'b0;
	logic [7:0] tick      = 8'h00;

	// Design outputs.
	logic [7:0] reg_rdata;
	logic       dot_clock;
	logic       video_clock;
	logic       sysclk_out;
	logic       pix_pin;
	logic       latch0;
	logic       vga_only;
	logic [2:0] run;
	logic [2:0] locked;

	// Bookkeeping.
	int         mismatches  = 0;
	int         comparisons = 0;
	int         cycles      = 0;
	int         dcnt        = 0;
	int         gap         = 0;
	int         vrises      = 0;
	int         srises      = 0;
	int         s0;
	int         v0;
	logic       pd          = 1'b0;
	logic       pv          = 1'b0;
	logic       ps          = 1'b0;
	logic [3:0] code;
	logic [7:0] nmp [3]     = '{8'hC5, 8'h12, 8'h80};

	dot_clock_select #(.LOCK_CYCLES(LOCK_N)) dut (
		.clk_sys               (clk_sys),
		.reset                 (reset),
		.reg_index             (reg_index),
		.reg_write             (reg_write),
		.reg_read              (reg_read),
		.reg_wdata             (reg_wdata),
		.reg_rdata             (reg_rdata),
		.clock_input_zero      (in_zero),
		.clock_input_one       (in_one),
		.clock_input_two_p     (in_two_p),
		.clock_input_two_n     (in_two_n),
		.pixel_synth_clock     (in_pix),
		.dot_clock             (dot_clock),
		.video_clock           (video_clock),
		.sysclk_out            (sysclk_out),
		.pixel_synth_out_pin   (pix_pin),
		.latch_with_input_zero (latch0),
		.vga_only_mode         (vga_only),
		.synth_run             (run),
		.synth_locked          (locked)
	);

	// The system clock, 40 ns period.
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end

	// Clock pins: static levels from the pattern, or input one toggling every 8 cycles.
	// The slow toggle keeps the external clock well below half the system clock.
	always @(posedge clk_sys) begin
		tick     <= tick + 8'h01;
		in_zero  <= pat[0];
		in_one   <= run1 ? tick[3] : pat[1];
		in_two_p <= pat[2];
		in_two_n <= ~pat[2];
		in_pix   <= pat[3];
	end

	// Edge monitor: dot-clock rises between two video-clock rises give the divide ratio.
	always @(posedge clk_sys) begin
		pd <= dot_clock;
		pv <= video_clock;
		ps <= sysclk_out;
		if (sysclk_out === 1'b1 && ps === 1'b0) srises <= srises + 1;
		if (video_clock === 1'b1 && pv === 1'b0) begin
			vrises <= vrises + 1;
			gap    <= dcnt;
			dcnt   <= (dot_clock === 1'b1 && pd === 1'b0) ? 1 : 0;
		end else if (dot_clock === 1'b1 && pd === 1'b0) begin
			dcnt <= dcnt + 1;
		end
	end

	// Hang guard: the whole run needs well under this many cycles.
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			mismatches = mismatches + 1;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One write strobe; the strobe drops at the taking edge.
	task automatic wr(input logic [7:0] idx, input logic [7:0] data);
		@(posedge clk_sys);
		reg_index <= idx;
		reg_wdata <= data;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
	endtask

	// One read strobe; the data is registered at the taking edge.
	task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_index <= idx;
		reg_read  <= 1'b1;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	task automatic wait_vid(input int n);
		int start;
		start = vrises;
		for (int i = 0; i < 5000 && vrises < start + n; i++) @(posedge clk_sys);
	endtask

	function automatic logic exp_dot(input logic [3:0] c, input logic [3:0] p);
		case (c)
			SRC_IN0_LATCH, SRC_IN0_VGA: return p[0];
			SRC_IN1:                    return p[1];
			SRC_IN2_A, SRC_IN2_B, SRC_ECL: return p[2];
			SRC_PIXEL:                  return p[3];
			default:                    return 1'b0;
		endcase
	endfunction

	// Main sequence.
	initial begin
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		rchk(IDX_CLOCK_SOURCE_SELECT, CSR_RESET);
		chk({6'h00, latch0, vga_only}, 8'h03);
		$display("Test reset state done");

		// Source codes 0 to 7 and reserved codes 9 and 15 against one-hot and one-cold pin patterns.
		for (int c = 0; c < 10; c++) begin
			code = (c < 8) ? 4'(c) : ((c == 8) ? 4'h9 : 4'hF);
			wr(IDX_CLOCK_SOURCE_SELECT, {4'h0, code});
			rchk(IDX_CLOCK_SOURCE_SELECT, {4'h0, code});
			chk({6'h00, latch0, vga_only}, (code == SRC_IN0_VGA) ? 8'h03 : 8'h00);
			for (int k = 0; k < 8; k++) begin
				@(posedge clk_sys);
				pat <= (k < 4) ? (4'h1 << k) : ~(4'h1 << (k - 4));
				repeat (8) @(posedge clk_sys);
				#1;
				chk({7'h00, dot_clock}, {7'h00, exp_dot(code, pat)});
			end
		end
		$display("Test source selection done");

		// Divider ratios with the system clock output enabled.
		@(posedge clk_sys);
		run1 <= 1'b1;
		s0 = srises;
		for (int d = 0; d < 7; d++) begin
			wr(IDX_CLOCK_SOURCE_SELECT, {1'b1, 3'(d), SRC_IN1});
			wait_vid(3);
			chk(8'(gap), 8'h01 << d);
		end
		chk({7'h00, srises > s0}, 8'h01);
		wr(IDX_CLOCK_SOURCE_SELECT, {1'b1, DIV_HOLD, SRC_IN1});
		repeat (10) @(posedge clk_sys);
		v0 = vrises;
		repeat (200) @(posedge clk_sys);
		chk(8'(vrises - v0), 8'h00);
		chk({7'h00, video_clock}, 8'h00);
		wr(IDX_CLOCK_SOURCE_SELECT, {1'b0, 3'h1, SRC_IN1});
		repeat (10) @(posedge clk_sys);
		v0 = vrises;
		s0 = srises;
		repeat (200) @(posedge clk_sys);
		chk({7'h00, vrises > v0}, 8'h01);
		chk(8'(srises - s0), 8'h00);
		run1 <= 1'b0;
		$display("Test video divider done");

		// Pixel synthesizer programming walk, lock poll and pointer behaviour.
		wr(IDX_SYNTH_POINTER, 8'h00);
		wr(IDX_PIXEL_SYNTH_DATA, nmp[0]);
		wr(IDX_PIXEL_SYNTH_DATA, nmp[1]);
		wr(IDX_PIXEL_SYNTH_DATA, nmp[2]);
		rchk(IDX_SYNTH_POINTER, 8'h03);
		chk({5'h00, run}, 8'h01);
		repeat (LOCK_N + 4) @(posedge clk_sys);
		rchk(IDX_PIXEL_SYNTH_DATA, 8'h40);
		rchk(IDX_PIXEL_SYNTH_DATA, 8'h40);
		rchk(IDX_SYNTH_POINTER, 8'h03);
		chk({5'h00, locked}, 8'h01);
		wr(IDX_PIXEL_SYNTH_DATA, 8'hFF);
		rchk(IDX_SYNTH_POINTER, 8'h00);
		for (int p = 0; p < 3; p++) begin
			wr(IDX_SYNTH_POINTER, 8'(p));
			rchk(IDX_PIXEL_SYNTH_DATA, nmp[p]);
			rchk(IDX_SYNTH_POINTER, 8'(p));
		end
		wr(IDX_SYNTH_POINTER, 8'h03);
		rchk(IDX_PIXEL_SYNTH_DATA, 8'h40);
		wr(IDX_SYNTH_POINTER, 8'hFF);
		rchk(IDX_SYNTH_POINTER, 8'h3F);
		$display("Test pixel synthesizer done");

		// Memory and loop pointers move on their own ports only.
		wr(IDX_SYNTH_POINTER, 8'h00);
		wr(IDX_MEMORY_SYNTH_DATA, 8'hC8);
		wr(IDX_LOOP_SYNTH_DATA, 8'hC8);
		wr(IDX_LOOP_SYNTH_DATA, 8'h10);
		rchk(IDX_SYNTH_POINTER, 8'h24);
		wr(IDX_MEMORY_SYNTH_DATA, 8'h10);
		wr(IDX_MEMORY_SYNTH_DATA, 8'h80);
		rchk(IDX_SYNTH_POINTER, 8'h2C);
		chk({5'h00, run}, 8'h03);
		wr(IDX_SYNTH_POINTER, 8'h02);
		wr(IDX_PIXEL_SYNTH_DATA, 8'h00);
		rchk(IDX_SYNTH_POINTER, 8'h03);
		chk({5'h00, run}, 8'h02);
		repeat (LOCK_N + 4) @(posedge clk_sys);
		chk({5'h00, locked}, 8'h02);
		$display("Test memory and loop synthesizers done");

		// Pixel synthesizer output pin gate.
		@(posedge clk_sys);
		pat <= 4'h8;
		wr(IDX_SYNTH_POINTER, 8'h02);
		wr(IDX_PIXEL_SYNTH_DATA, 8'hC0);
		repeat (8) @(posedge clk_sys);
		#1;
		chk({7'h00, pix_pin}, 8'h01);
		// The synthesizer is seen to lock before it is selected as the dot clock.
		chk({5'h00, locked}, 8'h03);
		wr(IDX_CLOCK_SOURCE_SELECT, {4'h0, SRC_PIXEL});
		repeat (8) @(posedge clk_sys);
		#1;
		chk({7'h00, dot_clock}, 8'h01);
		wr(IDX_SYNTH_POINTER, 8'h02);
		wr(IDX_PIXEL_SYNTH_DATA, 8'h80);
		repeat (8) @(posedge clk_sys);
		#1;
		chk({7'h00, pix_pin}, 8'h00);
		$display("Test output pin done");

		// An unmapped index stores nothing and reads zero.
		wr(8'h30, 8'h5A);
		rchk(8'h30, 8'h00);
		rchk(IDX_CLOCK_SOURCE_SELECT, 8'h05);
		$display("Test unmapped index done");
		complete_run();
	end

endmodule

`default_nettype wire

// File: hw/dot_clock_pkg.sv
// Package of register indices, field positions, codes and timing for the dot-clock block.
`default_nettype none

package dot_clock_pkg;

	// Register indices in the indirect map.
	localparam logic [7:0] IDX_CLOCK_SOURCE_SELECT = 8'h1A;
	localparam logic [7:0] IDX_SYNTH_POINTER       = 8'h2C;
	localparam logic [7:0] IDX_PIXEL_SYNTH_DATA    = 8'h2D;
	localparam logic [7:0] IDX_MEMORY_SYNTH_DATA   = 8'h2E;
	localparam logic [7:0] IDX_LOOP_SYNTH_DATA     = 8'h2F;

	// Reset values.
	localparam logic [7:0] CSR_RESET           = 8'h07;
	localparam logic [5:0] SYNTH_POINTER_RESET = 6'h00;
	localparam logic [7:0] SYNTH_REG_RESET     = 8'h00;

	// Field positions of the clock-selection register.
	localparam int SRC_LSB       = 0;
	localparam int SRC_MSB       = 3;
	localparam int DIV_LSB       = 4;
	localparam int DIV_MSB       = 6;
	localparam int SYSCLK_EN_BIT = 7;

	// Dot-clock source codes.
	localparam logic [3:0] SRC_IN0_LATCH = 4'h0;
	localparam logic [3:0] SRC_IN1       = 4'h1;
	localparam logic [3:0] SRC_IN2_A     = 4'h2;
	localparam logic [3:0] SRC_IN2_B     = 4'h3;
	localparam logic [3:0] SRC_ECL       = 4'h4;
	localparam logic [3:0] SRC_PIXEL     = 4'h5;
	localparam logic [3:0] SRC_STOP      = 4'h6;
	localparam logic [3:0] SRC_IN0_VGA   = 4'h7;
	localparam int         SRC_RSVD_BIT  = 3;

	// Video divider code that holds the video clock low.
	localparam logic [2:0] DIV_HOLD = 3'h7;

	// Pointer codes and pointer field positions.
	localparam logic [1:0] PTR_N      = 2'h0;
	localparam logic [1:0] PTR_M      = 2'h1;
	localparam logic [1:0] PTR_P      = 2'h2;
	localparam logic [1:0] PTR_STATUS = 2'h3;
	localparam int         PTR_WIDTH  = 2;
	localparam int         NUM_SYNTH  = 3;

	// Bit positions inside the synthesizer registers.
	localparam int P_RUN_BIT    = 7;
	localparam int P_OUT_EN_BIT = 6;
	localparam int LOCK_BIT     = 6;

	// Settling time before a running synthesizer reports lock.
	localparam int CLK_PERIOD_NS      = 40;
	localparam int LOCK_SETTLE_NS     = 1000;
	localparam int LOCK_SETTLE_CYCLES = (LOCK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

`default_nettype wire

// File: hw/dot_clock_select.sv
// Dot-clock source selection, video divider and synthesizer register access.
// Overview of operation
// - Clock-selection register resets to 0x07, input zero drives the dot clock.
// - Low selection bits 111: input zero clocks and latches VGA data and blank.
// - Low bits 000: input zero clocks, latch clock latches; either port usable.
// - Source field: 1 input one, 2/3 input two, 4 ECL pair, 5 synthesizer.
// - Source code 6 stops the internal dot clock to save power.
// - Bits six to four divide the dot clock by 2^n; value 7 holds zero.
// - Bit 7 of clock selection enables the system clock output.
// - Pointer register is readable, writable, holds three 2-bit pointers.
// - Pointer codes 00 N, 01 M, 10 P, 11 read-only status.
// - Indices 0x2D, 0x2E, 0x2F reach pixel, memory and loop synthesizer.
// - A data-port write increments only that synthesizer's pointer.
// - Data-port reads leave the pointer unchanged.
// - P-value bit 6 of the pixel synthesizer drives its output pin.
// - Each synthesizer is enabled or disabled independently.
// - Status bit 6 reads one once the loop has locked.
// - P-value bit 7 zero holds the synthesizer in reset; one runs it.
`default_nettype none

module dot_clock_select #(
	parameter int LOCK_CYCLES = dot_clock_pkg::LOCK_SETTLE_CYCLES
) (
	// Clock and reset.
	input  wire logic                                clk_sys,
	input  wire logic                                reset,
	// Indirect register port.
	input  wire logic [7:0]                          reg_index,
	input  wire logic                                reg_write,
	input  wire logic                                reg_read,
	input  wire logic [7:0]                          reg_wdata,
	output var  logic [7:0]                          reg_rdata,
	// External clock pins and the synthesized pixel clock.
	input  wire logic                                clock_input_zero,
	input  wire logic                                clock_input_one,
	input  wire logic                                clock_input_two_p,
	input  wire logic                                clock_input_two_n,
	input  wire logic                                pixel_synth_clock,
	// Clock outputs.
	output var  logic                                dot_clock,
	output var  logic                                video_clock,
	output var  logic                                sysclk_out,
	output var  logic                                pixel_synth_out_pin,
	// Latch mode of the VGA port.
	output var  logic                                latch_with_input_zero,
	output var  logic                                vga_only_mode,
	// Synthesizer state.
	output var  logic [dot_clock_pkg::NUM_SYNTH-1:0] synth_run,
	output var  logic [dot_clock_pkg::NUM_SYNTH-1:0] synth_locked
);

	import dot_clock_pkg::*;

	logic [7:0] clock_source_select;
	logic [5:0] synth_pointer;
	logic [5:0] next_synth_pointer;
	logic [4:0] pins;
	logic [5:0] div_count;
	logic       dot_prev;

	wire  [3:0] source_code = clock_source_select[SRC_MSB:SRC_LSB];
	wire  [2:0] div_code    = clock_source_select[DIV_MSB:DIV_LSB];
	wire        pin_zero    = pins[0];
	wire        pin_one     = pins[1];
	wire        pin_two_p   = pins[2];
	wire        pin_two_n   = pins[3];
	wire        pin_synth   = pins[4];

	// Index decode of the register port.
	wire write_csr     = reg_write && (reg_index == IDX_CLOCK_SOURCE_SELECT);
	wire write_pointer = reg_write && (reg_index == IDX_SYNTH_POINTER);
	wire [NUM_SYNTH-1:0] write_data_port;
	assign write_data_port[0] = reg_write && (reg_index == IDX_PIXEL_SYNTH_DATA);
	assign write_data_port[1] = reg_write && (reg_index == IDX_MEMORY_SYNTH_DATA);
	assign write_data_port[2] = reg_write && (reg_index == IDX_LOOP_SYNTH_DATA);

	wire [7:0]           port_rdata [NUM_SYNTH];
	wire [NUM_SYNTH-1:0] run_w;
	wire [NUM_SYNTH-1:0] out_en_w;
	wire [NUM_SYNTH-1:0] lock_w;

	// All external clocks are sampled; the system clock must be well above them.
	pin_sync #(
		.WIDTH (5)
	) u_pin_sync (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.pin_raw   ({pixel_synth_clock, clock_input_two_n, clock_input_two_p,
		             clock_input_one, clock_input_zero}),
		.pin_level (pins)
	);

	// One pointer and one register set per synthesizer, each on its own.
	genvar s;
	generate
		for (s = 0; s < NUM_SYNTH; s++) begin : g_synth
			wire [1:0] ptr = synth_pointer[PTR_WIDTH*s +: PTR_WIDTH];
			// Only a pointer-register write or a write to this port moves this pointer; reads never do.
			assign next_synth_pointer[PTR_WIDTH*s +: PTR_WIDTH] =
				write_pointer      ? reg_wdata[PTR_WIDTH*s +: PTR_WIDTH] :
				write_data_port[s] ? ptr + 2'h1 :
				ptr;
			synth_channel #(
				.LOCK_CYCLES (LOCK_CYCLES)
			) u_channel (
				.clk_sys    (clk_sys),
				.reset      (reset),
				.pointer    (ptr),
				.write_en   (write_data_port[s]),
				.write_data (reg_wdata),
				.read_data  (port_rdata[s]),
				.synth_run  (run_w[s]),
				.out_enable (out_en_w[s]),
				.locked     (lock_w[s])
			);
		end
	endgenerate

	// Register writes; the pointer reset value is a defined zero for safety.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			clock_source_select <= CSR_RESET;
			synth_pointer       <= SYNTH_POINTER_RESET;
		end else begin
			if (write_csr) begin
				clock_source_select <= reg_wdata;
			end
			synth_pointer <= next_synth_pointer;
		end
	end

	// Read-back mux; unmapped indices read zero, unused pointer bits read zero.
	wire [7:0] read_mux =
		(reg_index == IDX_CLOCK_SOURCE_SELECT) ? clock_source_select :
		(reg_index == IDX_SYNTH_POINTER)       ? {2'b00, synth_pointer} :
		(reg_index == IDX_PIXEL_SYNTH_DATA)    ? port_rdata[0] :
		(reg_index == IDX_MEMORY_SYNTH_DATA)   ? port_rdata[1] :
		(reg_index == IDX_LOOP_SYNTH_DATA)     ? port_rdata[2] :
		8'h00;

	// Read data is held until the next read so software may sample it late.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			reg_rdata <= read_mux;
		end
	end

	// Source selection; the ECL pair follows the true leg only while legs differ.
	wire ecl_level = (pin_two_p != pin_two_n) ? pin_two_p : dot_clock;
	wire dot_sel =
		source_code[SRC_RSVD_BIT]     ? 1'b0 :
		(source_code == SRC_IN0_VGA)  ? pin_zero :
		(source_code == SRC_IN0_LATCH) ? pin_zero :
		(source_code == SRC_IN1)      ? pin_one :
		(source_code == SRC_IN2_A)    ? pin_two_p :
		(source_code == SRC_IN2_B)    ? pin_two_p :
		(source_code == SRC_ECL)      ? ecl_level :
		(source_code == SRC_PIXEL)    ? pin_synth :
		1'b0;

	// Video divider taps a free counter of dot-clock rising edges.
	wire dot_rise  = dot_clock && !dot_prev;
	wire video_sel =
		(div_code == 3'h0)     ? dot_clock :
		(div_code == DIV_HOLD) ? 1'b0 :
		div_count[div_code - 3'h1];

	// Clock outputs, all registered so that no decode glitch leaves the block.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			dot_clock   <= 1'b0;
			dot_prev    <= 1'b0;
			div_count   <= 6'h00;
			video_clock <= 1'b0;
			sysclk_out  <= 1'b0;
		end else begin
			dot_clock   <= dot_sel;
			dot_prev    <= dot_clock;
			div_count   <= dot_rise ? div_count + 6'h01 : div_count;
			video_clock <= video_sel;
			sysclk_out  <= clock_source_select[SYSCLK_EN_BIT] && video_sel;
		end
	end

	// Latch mode flags and synthesizer state outputs.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			latch_with_input_zero <= 1'b1;
			vga_only_mode         <= 1'b1;
			pixel_synth_out_pin   <= 1'b0;
			synth_run             <= '0;
			synth_locked          <= '0;
		end else begin
			latch_with_input_zero <= (source_code == SRC_IN0_VGA);
			vga_only_mode         <= (source_code == SRC_IN0_VGA);
			pixel_synth_out_pin   <= out_en_w[0] && pin_synth;
			synth_run             <= run_w;
			synth_locked          <= lock_w;
		end
	end

	// Checks on the behaviour above.
	sequence s_pixel_write;
		reg_write && (reg_index == IDX_PIXEL_SYNTH_DATA);
	endsequence

	// A write through the pixel port while its pointer rests on the read-only status.
	sequence s_status_write;
		reg_write && (reg_index == IDX_PIXEL_SYNTH_DATA) && (synth_pointer[1:0] == PTR_STATUS);
	endsequence

	property p_csr_reset;
		@(posedge clk_sys) $past(reset) && !reset |->
			(clock_source_select == CSR_RESET) && latch_with_input_zero;
	endproperty
	a_csr_reset: assert property (p_csr_reset) else $error("clock select wrong after reset");

	property p_vga_mode;
		@(posedge clk_sys) disable iff (reset)
			(source_code == SRC_IN0_VGA) |=> latch_with_input_zero && vga_only_mode;
	endproperty
	a_vga_mode: assert property (p_vga_mode) else $error("input zero latch mode not shown");

	property p_latch_mode;
		@(posedge clk_sys) disable iff (reset)
			(source_code == SRC_IN0_LATCH) |=> !latch_with_input_zero && !vga_only_mode;
	endproperty
	a_latch_mode: assert property (p_latch_mode) else $error("latch clock mode not shown");

	property p_stop;
		@(posedge clk_sys) disable iff (reset)
			(source_code == SRC_STOP || source_code[SRC_RSVD_BIT]) [*2] |-> !dot_clock;
	endproperty
	a_stop: assert property (p_stop) else $error("dot clock runs while stopped");

	property p_input_one;
		@(posedge clk_sys) disable iff (reset)
			(source_code == SRC_IN1) |=> (dot_clock == $past(pin_one));
	endproperty
	a_input_one: assert property (p_input_one) else $error("dot clock not from input one");

	property p_div_hold;
		@(posedge clk_sys) disable iff (reset)
			(div_code == DIV_HOLD) [*2] |-> !video_clock && !sysclk_out;
	endproperty
	a_div_hold: assert property (p_div_hold) else $error("video clock not held low");

	property p_sysclk_gate;
		@(posedge clk_sys) disable iff (reset)
			!clock_source_select[SYSCLK_EN_BIT] |=> !sysclk_out;
	endproperty
	a_sysclk_gate: assert property (p_sysclk_gate) else $error("system clock out not gated");

	property p_write_incr;
		@(posedge clk_sys) disable iff (reset)
			s_pixel_write |=> (synth_pointer[1:0] == $past(synth_pointer[1:0]) + 2'h1)
				&& (synth_pointer[5:2] == $past(synth_pointer[5:2]));
	endproperty
	a_write_incr: assert property (p_write_incr) else $error("pointer increment wrong");

	property p_read_hold;
		@(posedge clk_sys) disable iff (reset)
			reg_read && !reg_write |=> (synth_pointer == $past(synth_pointer));
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("pointer moved on read");

	property p_status_wrap;
		@(posedge clk_sys) disable iff (reset)
			s_status_write |=> (synth_pointer[1:0] == PTR_N)
				&& (synth_pointer[5:2] == $past(synth_pointer[5:2]));
	endproperty
	a_status_wrap: assert property (p_status_wrap) else $error("status write misbehaved");

	property p_lock_read;
		@(posedge clk_sys) disable iff (reset)
			reg_read && (reg_index == IDX_PIXEL_SYNTH_DATA) && (synth_pointer[1:0] == PTR_STATUS)
				|=> (reg_rdata[LOCK_BIT] == $past(lock_w[0]));
	endproperty
	a_lock_read: assert property (p_lock_read) else $error("lock bit read wrong");

	property p_pixel_pin;
		@(posedge clk_sys) disable iff (reset)
			!out_en_w[0] |=> !pixel_synth_out_pin;
	endproperty
	a_pixel_pin: assert property (p_pixel_pin) else $error("pixel pin driven while off");

	property p_run_reset;
		@(posedge clk_sys) disable iff (reset)
			!run_w[1] |-> !lock_w[1] ##1 !synth_locked[1];
	endproperty
	a_run_reset: assert property (p_run_reset) else $error("held synthesizer shows lock");

endmodule

`default_nettype wire

// File: hw/pin_sync.sv
// Three-stage synchronizer for pins that come from outside the system clock domain.
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input  wire logic             clk_sys,
	input  wire logic             reset,
	// Raw pins and their filtered level.
	input  wire logic [WIDTH-1:0] pin_raw,
	output var  logic [WIDTH-1:0] pin_level
);

	genvar b;

	// Each bit takes a new level only when the second and third stages agree.
	generate
		for (b = 0; b < WIDTH; b++) begin : g_bit
			logic stage1;
			logic stage2;
			logic stage3;
			always_ff @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					stage1       <= 1'b0;
					stage2       <= 1'b0;
					stage3       <= 1'b0;
					pin_level[b] <= 1'b0;
				end else begin
					stage1 <= pin_raw[b];
					stage2 <= stage1;
					stage3 <= stage2;
					if (stage2 == stage3) begin
						pin_level[b] <= stage3;
					end
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// File: hw/synth_channel.sv
// One frequency synthesizer's N, M, P and status registers with a lock timer.
`default_nettype none

module synth_channel #(
	parameter int LOCK_CYCLES = dot_clock_pkg::LOCK_SETTLE_CYCLES
) (
	// Clock and reset.
	input  wire logic       clk_sys,
	input  wire logic       reset,
	// Access through the data port.
	input  wire logic [1:0] pointer,
	input  wire logic       write_en,
	input  wire logic [7:0] write_data,
	output logic      [7:0] read_data,
	// Control and state of the synthesizer.
	output logic            synth_run,
	output logic            out_enable,
	output logic            locked
);

	import dot_clock_pkg::*;

	logic [7:0]  value_n;
	logic [7:0]  value_m;
	logic [7:0]  value_p;
	logic [15:0] settle_count;

	// Status is read-only; a write aimed at it lands nowhere.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			value_n <= SYNTH_REG_RESET;
			value_m <= SYNTH_REG_RESET;
			value_p <= SYNTH_REG_RESET;
		end else if (write_en) begin
			case (pointer)
				PTR_N:   value_n <= write_data;
				PTR_M:   value_m <= write_data;
				PTR_P:   value_p <= write_data;
				default: value_n <= value_n;
			endcase
		end
	end

	// The run bit low holds the loop in reset; lock comes only after settling.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			settle_count <= 16'h0000;
		end else if (!value_p[P_RUN_BIT]) begin
			settle_count <= 16'h0000;
		end else if (settle_count != 16'(LOCK_CYCLES)) begin
			settle_count <= settle_count + 16'h0001;
		end
	end

	assign synth_run  = value_p[P_RUN_BIT];
	assign out_enable = value_p[P_OUT_EN_BIT];
	assign locked     = value_p[P_RUN_BIT] && (settle_count == 16'(LOCK_CYCLES));

	// Register selected by the pointer; other status bits read as zero.
	assign read_data = (pointer == PTR_N) ? value_n :
	                   (pointer == PTR_M) ? value_m :
	                   (pointer == PTR_P) ? value_p :
	                   {1'b0, locked, 6'h00};

	// A write aimed at the status register must leave N, M and P as they were.
	property p_status_keep;
		@(posedge clk_sys) disable iff (reset)
			write_en && (pointer == PTR_STATUS) |=>
				$stable(value_n) && $stable(value_m) && $stable(value_p);
	endproperty
	a_status_keep: assert property (p_status_keep) else $error("status write stored");

endmodule

`default_nettype wire
